// [rtl/rtbo_pkg.sv]
// Package with register map, field layout and carrier types of the tamper/backup/output block
package rtbo_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL      = 8'h00;
   localparam logic [7:0] OFF_TAMP      = 8'h04;
   localparam logic [7:0] OFF_STAT      = 8'h08;
   localparam logic [7:0] OFF_BKP_BASE  = 8'h50;
   localparam int unsigned BKP_WORDS    = 20;
   localparam logic [7:0] OFF_BKP_END   = 8'ha0;

   // Control register fields
   localparam int unsigned CTRL_CAL_EN  = 23;
   localparam int unsigned CTRL_ALM_SEL = 21;
   localparam int unsigned CTRL_ALM_INV = 20;
   localparam int unsigned CTRL_CAL_SEL = 19;
   localparam int unsigned CTRL_TS_IRQ  = 15;
   localparam int unsigned CTRL_WUT_IRQ = 14;
   localparam int unsigned CTRL_ALB_IRQ = 13;
   localparam int unsigned CTRL_ALA_IRQ = 12;
   localparam logic [31:0] CTRL_MASK    = 32'h00f8_f000;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

   // Tamper configuration register fields
   localparam int unsigned TAMP_EN      = 0;
   localparam int unsigned TAMP_TRG     = 1;
   localparam int unsigned TAMP_IE      = 2;
   localparam int unsigned TAMP_TS      = 7;
   localparam int unsigned TAMP_FREQ    = 8;
   localparam int unsigned TAMP_FLT     = 11;
   localparam int unsigned TAMP_PRCH    = 13;
   localparam int unsigned TAMP_PUDIS   = 15;
   localparam int unsigned TAMP_OTYPE   = 18;
   localparam logic [31:0] TAMP_MASK    = 32'h0004_ff87;
   localparam logic [31:0] TAMP_RST     = 32'h0000_0000;

   // Status register bits
   localparam int unsigned ST_ALRA      = 0;
   localparam int unsigned ST_ALRB      = 1;
   localparam int unsigned ST_WUT       = 2;
   localparam int unsigned ST_TS        = 3;
   localparam int unsigned ST_TSOV      = 4;
   localparam int unsigned ST_TAMP      = 5;
   localparam int unsigned ST_SHP       = 6;
   localparam int unsigned FLAG_W       = 6;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 6'h00;

   // Counter widths and tap positions
   localparam int unsigned SAMPLE_CNT_W = 15;
   localparam int unsigned MATCH_W      = 4;
   localparam int unsigned APRE_W       = 7;
   localparam int unsigned SPRE_W       = 15;
   localparam int unsigned CAL_APRE_TAP = 5;
   localparam int unsigned CAL_SYNC_TAP = 7;
   localparam int unsigned CAL_GAP_W    = 8;
   localparam logic [CAL_GAP_W-1:0] CAL_GAP_64 = 8'h3f;

   typedef enum logic [1:0] {
      ALM_OFF = 2'b00,
      ALM_A   = 2'b01,
      ALM_B   = 2'b10,
      ALM_WUT = 2'b11
   } rtbo_alm_sel_t;

   typedef struct packed {
      logic       enable;
      logic       trigger;
      logic [1:0] filter;
      logic [2:0] rate;
      logic [1:0] prch;
      logic       pudis;
   } rtbo_tamp_cfg_t;

   typedef struct packed {
      logic tamp;
      logic tsov;
      logic ts;
      logic wut;
      logic alrb;
      logic alra;
   } rtbo_flags_t;

endpackage : rtbo_pkg

// [rtl/rtbo_tamper_det.sv]
// Tamper input detector: edge mode or sampled level mode with filter and precharge
`timescale 1ns/1ns
module rtbo_tamper_det (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   tamper_pin,
   input  wire rtbo_pkg::rtbo_tamp_cfg_t cfg,
   output logic                        event_o,
   output logic                        pullup_o
);
   localparam int unsigned W = rtbo_pkg::SAMPLE_CNT_W;
   localparam int unsigned M = rtbo_pkg::MATCH_W;

   logic [W-1:0] div_q;
   logic         armed_q;
   logic [M-1:0] match_q;
   logic [M-1:0] match_d;

   // Sample period halves for each step of the rate field
   wire [W-1:0] rate_mask = {W{1'b1}} >> cfg.rate;
   wire [W-1:0] phase     = div_q & rate_mask;
   wire         tick      = (phase == rate_mask);
   wire [W-1:0] left      = rate_mask - phase;
   wire [W-1:0] prch_len  = {{(W-1){1'b0}}, 1'b1} << cfg.prch;
   wire         in_prch   = (left < prch_len);

   wire         edge_mode = (cfg.filter == 2'b00);
   wire         active    = cfg.trigger ? ~tamper_pin : tamper_pin;
   wire         armed     = active & cfg.enable;
   wire [M-1:0] need      = {{(M-1){1'b0}}, 1'b1} << cfg.filter;
   wire         edge_evt  = edge_mode & armed & ~armed_q;
   wire         filt_evt  = ~edge_mode & cfg.enable & tick & active
                            & (match_q == need - {{(M-1){1'b0}}, 1'b1});

   always_comb begin
      match_d = match_q;
      if (!cfg.enable || edge_mode) begin
         match_d = '0;
      end else if (tick) begin
         if (!active) begin
            match_d = '0;
         end else if (match_q != need) begin
            match_d = match_q + {{(M-1){1'b0}}, 1'b1};
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_q    <= '0;
         armed_q  <= 1'b0;
         match_q  <= '0;
         event_o  <= 1'b0;
         pullup_o <= 1'b0;
      end else begin
         div_q    <= div_q + {{(W-1){1'b0}}, 1'b1};
         armed_q  <= armed;
         match_q  <= match_d;
         event_o  <= edge_evt | filt_evt;
         pullup_o <= ~edge_mode & cfg.enable & ~cfg.pudis & in_prch;
      end
   end

endmodule : rtbo_tamper_det

// [rtl/rtbo_top.sv]
// Backup words, tamper flags, calibration and alarm output and event routing
`timescale 1ns/1ns
module rtbo_top (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        tamper_pin,
   input  wire logic        alarm_a_evt,
   input  wire logic        alarm_b_evt,
   input  wire logic        wakeup_evt,
   input  wire logic        timestamp_evt,
   input  wire logic        shift_pending_flag,
   input  wire logic        low_speed_source,
   input  wire logic [6:0]  async_prescaler,
   input  wire logic [14:0] sync_prescaler,
   output logic             tamper_pullup_en,
   output logic             timestamp_capture,
   output logic             shared_pin_o,
   output logic             shared_pin_oe_n,
   output logic             shared_pin_af_mode,
   output logic             evt_line17,
   output logic             evt_line21,
   output logic             evt_line22,
   output logic             wake_sleep,
   output logic             wake_deep
);
   localparam int unsigned NB = rtbo_pkg::BKP_WORDS;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   logic [31:0]           ctrl_q;
   logic [31:0]           tamp_q;
   rtbo_pkg::rtbo_flags_t flags_q;
   rtbo_pkg::rtbo_flags_t flags_d;
   logic [31:0]           bkp_q [NB];
   logic [6:0]            apre_q;
   logic [14:0]           spre_q;
   logic                  tamp_evt;
   logic                  tamp_pull;

   // Bus request and address decode
   wire       req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr       = req & wb_we_i;
   wire       aligned  = (wb_adr_i[1:0] == 2'b00);
   wire       hit_ctrl = aligned & (wb_adr_i == rtbo_pkg::OFF_CTRL);
   wire       hit_tamp = aligned & (wb_adr_i == rtbo_pkg::OFF_TAMP);
   wire       hit_stat = aligned & (wb_adr_i == rtbo_pkg::OFF_STAT);
   wire       hit_bkp  = aligned & (wb_adr_i >= rtbo_pkg::OFF_BKP_BASE)
                         & (wb_adr_i < rtbo_pkg::OFF_BKP_END);
   wire [7:0] bkp_off  = wb_adr_i - rtbo_pkg::OFF_BKP_BASE;
   wire [4:0] bkp_idx  = bkp_off[6:2];

   // Control fields
   wire                     cal_out_enable    = ctrl_q[rtbo_pkg::CTRL_CAL_EN];
   wire rtbo_pkg::rtbo_alm_sel_t alarm_out_select =
      rtbo_pkg::rtbo_alm_sel_t'(ctrl_q[rtbo_pkg::CTRL_ALM_SEL +: 2]);
   wire                     alarm_out_polarity = ctrl_q[rtbo_pkg::CTRL_ALM_INV];
   wire                     cal_out_select    = ctrl_q[rtbo_pkg::CTRL_CAL_SEL];
   wire                     timestamp_irq_en  = ctrl_q[rtbo_pkg::CTRL_TS_IRQ];
   wire                     wakeup_irq_enable = ctrl_q[rtbo_pkg::CTRL_WUT_IRQ];
   wire                     alarm_b_irq_en    = ctrl_q[rtbo_pkg::CTRL_ALB_IRQ];
   wire                     alarm_a_irq_en    = ctrl_q[rtbo_pkg::CTRL_ALA_IRQ];
   wire                     tamper_irq_enable = tamp_q[rtbo_pkg::TAMP_IE];
   wire                     stamp_on_tamper   = tamp_q[rtbo_pkg::TAMP_TS];
   wire                     alarm_out_od      = tamp_q[rtbo_pkg::TAMP_OTYPE];

   rtbo_pkg::rtbo_tamp_cfg_t tcfg;
   assign tcfg.enable  = tamp_q[rtbo_pkg::TAMP_EN];
   assign tcfg.trigger = tamp_q[rtbo_pkg::TAMP_TRG];
   assign tcfg.filter  = tamp_q[rtbo_pkg::TAMP_FLT +: 2];
   assign tcfg.rate    = tamp_q[rtbo_pkg::TAMP_FREQ +: 3];
   assign tcfg.prch    = tamp_q[rtbo_pkg::TAMP_PRCH +: 2];
   assign tcfg.pudis   = tamp_q[rtbo_pkg::TAMP_PUDIS];

   rtbo_tamper_det u_det (
      .clk_sys    (clk_sys),
      .rst        (rst),
      .tamper_pin (tamper_pin),
      .cfg        (tcfg),
      .event_o    (tamp_evt),
      .pullup_o   (tamp_pull)
   );
   assign tamper_pullup_en = tamp_pull;

   // Timestamp trigger: external event or tamper when stamping is on
   wire ts_trig = timestamp_evt | (tamp_evt & stamp_on_tamper);
   wire ts_set  = ts_trig & ~flags_q.ts;
   wire ov_set  = ts_trig & flags_q.ts;

   // Status clear: write zero to a bit in byte lane 0
   wire [5:0] clr = (wr & hit_stat & wb_sel_i[0]) ? ~wb_dat_i[5:0] : 6'h00;

   // Set wins over clear on every flag but ts, where a trigger on an already set flag only sets tsov
   always_comb begin
      flags_d.alra = alarm_a_evt | (flags_q.alra & ~clr[rtbo_pkg::ST_ALRA]);
      flags_d.alrb = alarm_b_evt | (flags_q.alrb & ~clr[rtbo_pkg::ST_ALRB]);
      flags_d.wut  = wakeup_evt | (flags_q.wut & ~clr[rtbo_pkg::ST_WUT]);
      flags_d.ts   = ts_set | (flags_q.ts & ~clr[rtbo_pkg::ST_TS]);
      flags_d.tsov = ov_set | (flags_q.tsov & ~clr[rtbo_pkg::ST_TSOV]);
      flags_d.tamp = tamp_evt | (flags_q.tamp & ~clr[rtbo_pkg::ST_TAMP]);
   end

   // Read data selection
   logic [31:0] rd_data;
   logic [31:0] stat_rd;
   assign stat_rd = {25'h0, shift_pending_flag, flags_q};
   always_comb begin
      rd_data = 32'h0;
      if (hit_ctrl) begin
         rd_data = ctrl_q;
      end else if (hit_tamp) begin
         rd_data = tamp_q;
      end else if (hit_stat) begin
         rd_data = stat_rd;
      end else if (hit_bkp) begin
         rd_data = bkp_q[bkp_idx];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         ctrl_q   <= rtbo_pkg::CTRL_RST;
         tamp_q   <= rtbo_pkg::TAMP_RST;
         flags_q  <= rtbo_pkg::FLAGS_RST;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= (req & ~wb_we_i) ? rd_data : 32'h0;
         flags_q  <= flags_d;
         if (wr & hit_ctrl) begin
            ctrl_q <= merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & rtbo_pkg::CTRL_MASK;
         end
         if (wr & hit_tamp) begin
            tamp_q <= merge_bytes(tamp_q, wb_dat_i, wb_sel_i) & rtbo_pkg::TAMP_MASK;
         end
      end
   end

   // Backup words: only backup reset or tamper clears them
   for (genvar i = 0; i < NB; i++) begin : g_bkp
      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            bkp_q[i] <= 32'h0;
         end else if (tamp_evt) begin
            bkp_q[i] <= 32'h0;
         end else if (wr & hit_bkp & (bkp_idx == 5'(i))) begin
            bkp_q[i] <= merge_bytes(bkp_q[i], wb_dat_i, wb_sel_i);
         end
      end
   end

   // Prescaler chain feeding the calibration clock; no smooth correction here
   wire apre_wrap = (apre_q >= async_prescaler);
   wire spre_wrap = (spre_q >= sync_prescaler);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         apre_q <= 7'h00;
         spre_q <= 15'h0000;
      end else begin
         apre_q <= apre_wrap ? 7'h00 : apre_q + 7'h01;
         if (apre_wrap) begin
            spre_q <= spre_wrap ? 15'h0000 : spre_q + 15'h0001;
         end
      end
   end
   wire cal_src = cal_out_select ? spre_q[rtbo_pkg::CAL_SYNC_TAP]
                                 : apre_q[rtbo_pkg::CAL_APRE_TAP];

   // Alarm source and shared pin drive
   logic alarm_flag;
   always_comb begin
      case (alarm_out_select)
         rtbo_pkg::ALM_A:     alarm_flag = flags_q.alra;
         rtbo_pkg::ALM_B:     alarm_flag = flags_q.alrb;
         rtbo_pkg::ALM_WUT:   alarm_flag = flags_q.wut;
         default:             alarm_flag = 1'b0;
      endcase
   end
   wire alarm_on  = (alarm_out_select != rtbo_pkg::ALM_OFF);
   wire alarm_val = alarm_flag ^ alarm_out_polarity;
   wire pin_o_d   = alarm_on ? (alarm_val & ~alarm_out_od)
                             : (cal_out_enable & cal_src);
   wire pin_oe_d  = alarm_on ? ~(alarm_out_od & alarm_val)
                             : cal_out_enable;

   // Event lines and wake requests
   wire line17_d = (flags_q.alra & alarm_a_irq_en) | (flags_q.alrb & alarm_b_irq_en);
   wire line22_d = flags_q.wut & wakeup_irq_enable;
   wire line21_d = (flags_q.tamp & tamper_irq_enable)
                   | (flags_q.ts & timestamp_irq_en);
   wire wake_any = line17_d | line21_d | line22_d;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shared_pin_o       <= 1'b0;
         shared_pin_oe_n    <= 1'b1;
         shared_pin_af_mode <= 1'b0;
         evt_line17         <= 1'b0;
         evt_line21         <= 1'b0;
         evt_line22         <= 1'b0;
         wake_sleep         <= 1'b0;
         wake_deep          <= 1'b0;
         timestamp_capture  <= 1'b0;
      end else begin
         shared_pin_o       <= pin_o_d;
         shared_pin_oe_n    <= ~pin_oe_d;
         shared_pin_af_mode <= alarm_on | cal_out_enable;
         evt_line17         <= line17_d;
         evt_line21         <= line21_d;
         evt_line22         <= line22_d;
         wake_sleep         <= wake_any;
         wake_deep          <= wake_any & low_speed_source;
         timestamp_capture  <= ts_set;
      end
   end

   // Helper logic for the checks below
   logic                              cal_seen_q;
   logic [rtbo_pkg::CAL_GAP_W-1:0]    cal_gap_q;
   logic                              cal_src_q;
   wire  cal_rise = cal_src & ~cal_src_q;
   logic any_bkp_nz;
   always_comb begin
      any_bkp_nz = 1'b0;
      for (int k = 0; k < NB; k++) begin
         any_bkp_nz = any_bkp_nz | (bkp_q[k] != 32'h0);
      end
   end
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cal_seen_q <= 1'b0;
         cal_gap_q  <= '0;
         cal_src_q  <= 1'b0;
      end else begin
         cal_src_q  <= cal_src;
         cal_seen_q <= cal_seen_q | cal_rise;
         cal_gap_q  <= cal_rise ? '0 : cal_gap_q + 8'h01;
      end
   end
   wire cal_div64_mode = ~cal_out_select & (async_prescaler == 7'h7f);

   chk_bkp_clear: assert property (@(posedge clk_sys) disable iff (rst)
      tamp_evt |=> !any_bkp_nz)
      else $error("backup words not cleared after tamper");

   chk_tamp_disabled: assert property (@(posedge clk_sys) disable iff (rst)
      (!tcfg.enable ##1 !tcfg.enable) |-> !tamp_evt)
      else $error("tamper event while detection disabled");

   chk_tamp_flag_set: assert property (@(posedge clk_sys) disable iff (rst)
      (flags_q.tamp && !clr[rtbo_pkg::ST_TAMP]) |=> flags_q.tamp)
      else $error("tamper flag dropped without a clear");

   chk_stamp_same: assert property (@(posedge clk_sys) disable iff (rst)
      (tamp_evt && stamp_on_tamper && !flags_q.ts) |=> (flags_q.ts && flags_q.tamp))
      else $error("timestamp and tamper flags not set together");

   chk_stamp_overflow: assert property (@(posedge clk_sys) disable iff (rst)
      (tamp_evt && stamp_on_tamper && flags_q.ts) |=> (flags_q.tsov && !timestamp_capture))
      else $error("tamper stamp on set flag did not overflow");

   chk_edge_pullup: assert property (@(posedge clk_sys) disable iff (rst)
      (tcfg.filter == 2'b00) |=> !tamper_pullup_en)
      else $error("pull-up active in edge mode");

   chk_cal_div64: assert property (@(posedge clk_sys) disable iff (rst)
      (cal_rise && cal_seen_q && $stable(cal_div64_mode) && cal_div64_mode
       && $past(cal_div64_mode, 63)) |-> (cal_gap_q == rtbo_pkg::CAL_GAP_64))
      else $error("calibration clock not divided by 64");

   chk_alarm_prio: assert property (@(posedge clk_sys) disable iff (rst)
      (alarm_on && !alarm_out_od) |=> (shared_pin_af_mode && !shared_pin_oe_n
                                       && shared_pin_o == $past(alarm_val)))
      else $error("alarm output lost the shared pin");

   chk_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
      (alarm_on && alarm_out_od) |=> (shared_pin_o == 1'b0
                                      && shared_pin_oe_n == $past(alarm_val)))
      else $error("open-drain alarm drive wrong");

   chk_line21_hold: assert property (@(posedge clk_sys) disable iff (rst)
      (flags_q.tamp && tamper_irq_enable) |=> evt_line21)
      else $error("tamper request not raised on line 21");

   chk_wake_deep: assert property (@(posedge clk_sys) disable iff (rst)
      wake_deep |-> ($past(low_speed_source) && wake_sleep))
      else $error("deep wake without low-speed source");

   chk_bus_ack: assert property (@(posedge clk_sys) disable iff (rst)
      req |=> (wb_ack_o ##1 !wb_ack_o))
      else $error("bus acknowledge not a single cycle");

   chk_alarm_off: assert property (@(posedge clk_sys) disable iff (rst)
      (!alarm_on && !cal_out_enable) |=> (shared_pin_oe_n && !shared_pin_af_mode))
      else $error("shared pin driven with both outputs off");

   chk_stamp_capture: assert property (@(posedge clk_sys) disable iff (rst)
      (ts_trig && !flags_q.ts) |=> timestamp_capture)
      else $error("timestamp capture missing");

endmodule : rtbo_top

// [tb/rtbo_far_side.sv]
// Far-side model: tamper switch and board wiring of the shared output pin
`timescale 1ns/1ns
module rtbo_far_side (
   input  wire logic switch_level,
   input  wire logic shared_pin_o,
   input  wire logic shared_pin_oe_n,
   output logic      tamper_pin,
   output logic      pin_level
);
   // Switch drives the tamper line at all times
   assign tamper_pin = switch_level;
   // Released pin is held high by the board pull-up
   assign pin_level  = shared_pin_oe_n ? 1'h1 : shared_pin_o;
endmodule : rtbo_far_side

// [tb/testbench.sv]
// Self-checking bench for the tamper, backup and output block
`timescale 1ns/1ns
module testbench;
   localparam logic [7:0] CT = rtbo_pkg::OFF_CTRL;
   localparam logic [7:0] TP = rtbo_pkg::OFF_TAMP;
   localparam logic [7:0] ST = rtbo_pkg::OFF_STAT;
   localparam logic [7:0] BK = rtbo_pkg::OFF_BKP_BASE;
   logic        clk_sys = 1'h0, rst = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
   logic        alarm_a_evt = 1'h0, alarm_b_evt = 1'h0, wakeup_evt = 1'h0, switch_level = 1'h0;
   logic        timestamp_evt = 1'h0, shift_pending_flag = 1'h0, low_speed_source = 1'h1;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [6:0]  async_prescaler = 7'h7f;
   logic [14:0] sync_prescaler = 15'h00ff;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, tamper_pin, tamper_pullup_en, timestamp_capture, shared_pin_o;
   logic        shared_pin_oe_n, shared_pin_af_mode, evt_line17, evt_line21, evt_line22;
   logic        wake_sleep, wake_deep, pin_level;
   logic [31:0] bkp [20];
   int          err_total = 0, tests_run = 0, cyc = 0, p, caps = 0;

   rtbo_top      i_rtbo_top (.*);
   rtbo_far_side i_rtbo_far_side (.*);

   always #5 clk_sys = ~clk_sys;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      @(posedge clk_sys);
   endtask : wb

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      wb(1'h0, a, 32'h0);
      chk(rd, e);
   endtask : rc

   // Rise-to-rise period of the shared pin in clocks
   task automatic meas;
      p = 0;
      do @(posedge clk_sys); while (pin_level !== 1'h0);
      do @(posedge clk_sys); while (pin_level !== 1'h1);
      do begin @(posedge clk_sys); p++; end while (pin_level !== 1'h0);
      do begin @(posedge clk_sys); p++; end while (pin_level !== 1'h1);
   endtask : meas

   task automatic close_out;
      $display("err_total=%0d tests_run=%0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   always @(posedge clk_sys) begin
      cyc++;
      if (timestamp_capture === 1'h1) caps++;
      if (cyc == 20000) begin
         err_total++;
         close_out();
      end
   end

   initial begin
      void'($urandom(32'ha582));
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      rc(CT, rtbo_pkg::CTRL_RST);
      rc(TP, rtbo_pkg::TAMP_RST);
      rc(ST, 32'h0);
      for (int i = 0; i < 20; i++) begin
         bkp[i] = $urandom;
         wb(1'h1, BK + 8'(4 * i), bkp[i]);
      end
      wb(1'h1, 8'hc0, 32'hffff_ffff);
      rc(8'hc0, 32'h0);
      for (int i = 0; i < 20; i++) rc(BK + 8'(4 * i), bkp[i]);
      // Edge mode, rising, stamping and interrupt on
      wb(1'h1, TP, 32'h85);
      chk({tamper_pullup_en, shared_pin_af_mode}, 0);
      switch_level <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk(evt_line21, 1);
      rc(ST, 32'h28);
      chk(caps, 1);
      for (int i = 0; i < 20; i++) rc(BK + 8'(4 * i), 32'h0);
      wb(1'h1, ST, 32'h08);
      rc(ST, 32'h08);
      chk(evt_line21, 0);
      wb(1'h1, TP, 32'h0);
      switch_level <= 1'h0;
      repeat (2) @(posedge clk_sys);
      switch_level <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rc(ST, 32'h08);
      switch_level <= 1'h0;
      wb(1'h1, TP, 32'h1);
      wb(1'h1, BK, 32'h1234_5678);
      repeat (4) @(posedge clk_sys);
      rc(ST, 32'h08);
      rc(BK, 32'h1234_5678);
      // Falling trigger enabled with pin already low
      shift_pending_flag <= 1'h1;
      wb(1'h1, TP, 32'h83);
      repeat (4) @(posedge clk_sys);
      rc(ST, 32'h78);
      rc(BK, 32'h0);
      chk(caps, 1);
      shift_pending_flag <= 1'h0;
      wb(1'h1, ST, 32'h0);
      // Filtered level mode, two samples, fastest rate
      wb(1'h1, TP, 32'h0f01);
      repeat (600) @(posedge clk_sys);
      rc(ST, 32'h0);
      switch_level <= 1'h1;
      p = 0;
      repeat (900) begin
         @(posedge clk_sys);
         if (tamper_pullup_en === 1'h1) p = 1;
      end
      chk(p, 1);
      rc(ST, 32'h20);
      wb(1'h1, ST, 32'h0);
      // External timestamp pulse with its interrupt enabled
      wb(1'h1, CT, 32'h8000);
      timestamp_evt <= 1'h1;
      @(posedge clk_sys);
      timestamp_evt <= 1'h0;
      repeat (3) @(posedge clk_sys);
      chk(evt_line21, 1);
      chk(caps, 2);
      rc(ST, 32'h08);
      wb(1'h1, ST, 32'h0);
      // Alarm output codes and polarity, calibration also enabled
      for (int k = 2; k < 8; k++) begin
         low_speed_source <= 1'(k % 2);
         wb(1'h1, TP, 32'((k / 2) % 2) << 18);
         wb(1'h1, CT, 32'h80_7000 | (32'(k / 2) << 21) | (32'(k % 2) << 20));
         repeat (2) @(posedge clk_sys);
         chk(pin_level, k % 2);
         chk(shared_pin_af_mode, 1);
         alarm_a_evt <= (k / 2 == 1);
         alarm_b_evt <= (k / 2 == 2);
         wakeup_evt  <= (k / 2 == 3);
         @(posedge clk_sys);
         {alarm_a_evt, alarm_b_evt, wakeup_evt} <= 3'h0;
         repeat (4) @(posedge clk_sys);
         chk(pin_level, 1 - k % 2);
         chk(k < 6 ? evt_line17 : evt_line22, 1);
         chk({wake_sleep, wake_deep}, {1'h1, 1'(k % 2)});
         wb(1'h1, ST, 32'h0);
      end
      wb(1'h1, CT, 32'h80_0000);
      meas;
      chk(p, 64);
      async_prescaler <= 7'h01;
      wb(1'h1, CT, 32'h88_0000);
      meas;
      meas;
      chk(p, 512);
      close_out();
   end
endmodule : testbench
